// File: core/pin_ctrl.sv
// Module: flag pins, reset sequence and interrupt detection behind AHB-Lite
module pin_ctrl #(
  parameter int INT_COUNT = 4
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  clock_div2_mode,
  input  wire logic                  microcomputer_mode,
  input  wire logic [1:0]            user_flag_in,
  output logic      [1:0]            user_flag_out,
  output logic      [1:0]            user_flag_oe,
  output logic                       serial_timer_oe,
  output logic                       addr_oe,
  output logic                       page_strobes_oe,
  output logic                       data_oe,
  output logic                       strobe_n,
  output logic                       rw,
  output logic                       interrupt_acknowledge_out_n,
  output logic                       vector_fetch,
  input  wire logic                  hold_req,
  output logic                       hold_acknowledge,
  input  wire logic [INT_COUNT-1:0]  external_interrupt_pin_n,
  input  wire logic                  fetch_boundary,
  input  wire logic                  int_take,
  input  wire logic [1:0]            int_take_id,
  output logic      [INT_COUNT-1:0]  int_pending
);
  if (INT_COUNT < 1 || INT_COUNT > 4) begin : g_chk
    $error("INT_COUNT must lie between 1 and 4");
  end

  function automatic logic is_reg(logic [7:0] a, logic [7:0] off);
    return a == off;
  endfunction : is_reg

  // ------------------------------------------------------------
  // Phase enables
  // ------------------------------------------------------------
  logic half;
  logic phase;
  logic tick;
  logic h3_rise;
  logic h1_fall;
  assign tick    = clock_div2_mode ? half : 1'b1;
  assign h3_rise = tick & ~phase;
  assign h1_fall = tick & phase;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half  <= 1'b0;
      phase <= 1'b0;
    end else begin
      half <= ~half;
      if (tick) begin
        phase <= ~phase;
      end
    end
  end

  // ------------------------------------------------------------
  // Reset synchroniser and boot sequence
  // ------------------------------------------------------------
  logic                      rst_meta;
  logic                      rst_sync;
  logic                      micro_mode;
  logic                      fetch_idx;
  logic [2:0]                wait_cnt;
  logic [2:0]                bus_wait;
  pin_ctrl_pkg::boot_state_t boot_state;
  logic [2:0]                wait_goal;
  assign wait_goal = micro_mode ? 3'h0 : bus_wait;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Strap caught while still in the sync state, never under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      micro_mode <= 1'b0;
    end else if (boot_state == pin_ctrl_pkg::BOOT_SYNC) begin
      micro_mode <= microcomputer_mode;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_state   <= pin_ctrl_pkg::BOOT_SYNC;
      fetch_idx    <= 1'b0;
      wait_cnt     <= 3'h0;
      vector_fetch <= 1'b0;
    end else begin
      vector_fetch <= 1'b0;
      case (boot_state)
        pin_ctrl_pkg::BOOT_SYNC: begin
          // A pending hold keeps the bus parked before any fetch
          if (rst_sync && !hold_req) begin
            boot_state <= pin_ctrl_pkg::BOOT_FETCH;
          end
        end
        pin_ctrl_pkg::BOOT_FETCH: begin
          if (wait_cnt == wait_goal) begin
            wait_cnt     <= 3'h0;
            vector_fetch <= 1'b1;
            fetch_idx    <= 1'b1;
            if (fetch_idx) begin
              boot_state <= pin_ctrl_pkg::BOOT_RUN;
            end
          end else begin
            wait_cnt <= wait_cnt + 3'h1;
          end
        end
        pin_ctrl_pkg::BOOT_RUN: begin
          boot_state <= pin_ctrl_pkg::BOOT_RUN;
        end
        default: begin
          boot_state <= pin_ctrl_pkg::BOOT_SYNC;
        end
      endcase
    end
  end

  // hold granted only outside the BOOT_FETCH state, never during its wait cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_acknowledge <= 1'b0;
    end else begin
      hold_acknowledge <= hold_req &&
                          (boot_state != pin_ctrl_pkg::BOOT_FETCH);
    end
  end

  // bus pins parked until the sequence leaves sync
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_oe                     <= 1'b0;
      page_strobes_oe             <= 1'b0;
      data_oe                     <= 1'b0;
      strobe_n                    <= 1'b1;
      rw                          <= 1'b1;
      interrupt_acknowledge_out_n <= 1'b1;
    end else begin
      addr_oe         <= (boot_state != pin_ctrl_pkg::BOOT_SYNC) &&
                         !hold_acknowledge;
      page_strobes_oe <= (boot_state != pin_ctrl_pkg::BOOT_SYNC) &&
                         !hold_acknowledge;
      data_oe         <= 1'b0;
      strobe_n        <= boot_state != pin_ctrl_pkg::BOOT_FETCH;
      rw              <= 1'b1;
      interrupt_acknowledge_out_n <= ~(int_take & fetch_boundary);
    end
  end

  // serial and timer pins float with reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_timer_oe <= 1'b0;
    end else begin
      serial_timer_oe <= rst_sync;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  pin_ctrl_pkg::ahb_req_t req;
  logic [7:0]             io_flag;
  logic                   edge_sel;
  logic                   wr_io;
  logic                   wr_pnd;
  assign wr_io  = req.valid && req.write &&
                  is_reg(req.addr, pin_ctrl_pkg::OFF_IO_FLAG);
  assign wr_pnd = req.valid && req.write &&
                  is_reg(req.addr, pin_ctrl_pkg::OFF_INT_PND);

  // Zero wait states keep the slave trivially ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req       <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      req.valid <= hsel && hready && htrans[1];
      req.write <= hwrite;
      req.addr  <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        if (is_reg(haddr[7:0], pin_ctrl_pkg::OFF_IO_FLAG)) begin
          hrdata <= {24'h0, io_flag};
        end else if (is_reg(haddr[7:0], pin_ctrl_pkg::OFF_BUS_CTL)) begin
          hrdata <= {29'h0, bus_wait};
        end else if (is_reg(haddr[7:0], pin_ctrl_pkg::OFF_INT_CTL)) begin
          hrdata <= {31'h0, edge_sel};
        end else if (is_reg(haddr[7:0], pin_ctrl_pkg::OFF_INT_PND)) begin
          hrdata <= 32'(int_pending);
        end else if (is_reg(haddr[7:0], pin_ctrl_pkg::OFF_STATUS)) begin
          hrdata <= {28'h0, hold_acknowledge, micro_mode, boot_state};
        end else begin
          hrdata <= 32'h0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wait <= pin_ctrl_pkg::WAIT_RESET;
      edge_sel <= 1'b0;
    end else if (req.valid && req.write) begin
      if (is_reg(req.addr, pin_ctrl_pkg::OFF_BUS_CTL)) begin
        bus_wait <= hwdata[2:0];
      end
      if (is_reg(req.addr, pin_ctrl_pkg::OFF_INT_CTL)) begin
        edge_sel <= hwdata[pin_ctrl_pkg::EDGE_SEL_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Flag pins
  // ------------------------------------------------------------
  pin_ctrl_pkg::flag_pin_t flag [2];
  localparam int DIR_BIT [2] = '{pin_ctrl_pkg::FLAG0_DIR_BIT,
                                 pin_ctrl_pkg::FLAG1_DIR_BIT};
  localparam int OUT_BIT [2] = '{pin_ctrl_pkg::FLAG0_OUT_BIT,
                                 pin_ctrl_pkg::FLAG1_OUT_BIT};
  localparam int IN_BIT [2]  = '{pin_ctrl_pkg::FLAG0_IN_BIT,
                                 pin_ctrl_pkg::FLAG1_IN_BIT};

  for (genvar f = 0; f < 2; f++) begin : g_flag
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        io_flag[DIR_BIT[f]] <= 1'b0;
        io_flag[OUT_BIT[f]] <= 1'b0;
      end else if (wr_io) begin
        io_flag[DIR_BIT[f]] <= hwdata[DIR_BIT[f]];
        io_flag[OUT_BIT[f]] <= hwdata[OUT_BIT[f]];
      end
    end
    // input sampled only in input mode
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        io_flag[IN_BIT[f]] <= 1'b0;
      end else if (h1_fall && !flag[f].oe) begin
        io_flag[IN_BIT[f]] <= user_flag_in[f];
      end
    end
    // pin moves at phase three, floats in reset
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag[f] <= '0;
      end else if (h3_rise) begin
        flag[f].oe  <= io_flag[DIR_BIT[f]];
        flag[f].out <= io_flag[OUT_BIT[f]];
      end
    end
    assign user_flag_out[f] = flag[f].out;
    assign user_flag_oe[f]  = flag[f].oe;
  end
  assign io_flag[0] = 1'b0;
  assign io_flag[4] = 1'b0;

  // ------------------------------------------------------------
  // Interrupt detection
  // ------------------------------------------------------------
  logic [INT_COUNT-1:0] int_clr;
  logic [INT_COUNT-1:0] int_set;

  for (genvar i = 0; i < INT_COUNT; i++) begin : g_int
    logic       last_n;
    logic [1:0] rearm;
    // taken only at a fetch boundary
    assign int_clr[i] = (wr_pnd && hwdata[i]) ||
                        (int_take && fetch_boundary && int_take_id == 2'(i));
    assign int_set[i] = h1_fall && rearm == 2'h0 &&
                        !external_interrupt_pin_n[i] &&
                        (!edge_sel || last_n);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        last_n <= 1'b1;
      end else if (h1_fall) begin
        last_n <= external_interrupt_pin_n[i];
      end
    end
    // clear wins, then two phase-one cycles of hold-off
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        int_pending[i] <= 1'b0;
        rearm          <= 2'h0;
      end else if (int_clr[i]) begin
        int_pending[i] <= 1'b0;
        rearm          <= pin_ctrl_pkg::REARM_H1;
      end else begin
        if (int_set[i]) begin
          int_pending[i] <= 1'b1;
        end
        if (h1_fall && rearm != 2'h0) begin
          rearm <= rearm - 2'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // output only moves at phase three
  flag_moves_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !h3_rise |=> $stable(user_flag_out)) else $error("flag moved early");
  flag_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
    h3_rise |=> user_flag_out[1] == $past(io_flag[6]))
    else $error("flag 1 value wrong");
  flag_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
    h3_rise |=> user_flag_oe[0] == $past(io_flag[1]))
    else $error("flag 0 direction wrong");
  // input bit frozen in output mode
  flag_in_a: assert property (@(posedge hclk) disable iff (!hresetn)
    user_flag_oe[0] |=> $stable(io_flag[3])) else $error("input moved");
  boot_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rst_sync) |-> bus_wait == 3'h7) else $error("wait not seven");
  hold_grant_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (hold_req && boot_state == pin_ctrl_pkg::BOOT_SYNC) |->
    ##[1:9] (hold_acknowledge || !hold_req)) else $error("hold late");
  park_bus_a: assert property (@(posedge hclk) disable iff (!hresetn)
    boot_state == pin_ctrl_pkg::BOOT_SYNC |=> strobe_n && !addr_oe)
    else $error("bus driven in reset");
  two_fetch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(boot_state == pin_ctrl_pkg::BOOT_RUN) |-> vector_fetch && fetch_idx)
    else $error("run without fetch");
  // flags set only at phase-one falls
  int_sample_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(int_pending[0]) |-> $past(h1_fall)) else $error("set off phase");
  clr_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    int_clr[0] |=> !int_pending[0] ##1 !$rose(int_pending[0]))
    else $error("clear lost");
  // flag falls only on a clear
  pend_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(int_pending[0]) |-> $past(int_clr[0])) else $error("flag lost");
  // edge mode needs a high before
  edge_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (edge_sel && int_set[0]) |-> g_int[0].last_n) else $error("no edge");

endmodule : pin_ctrl

// File: common/pin_ctrl_pkg.sv
// Package: constants and types of the flag, reset and interrupt pin logic
package pin_ctrl_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_IO_FLAG = 8'h00;
  localparam logic [7:0] OFF_BUS_CTL = 8'h04;
  localparam logic [7:0] OFF_INT_CTL = 8'h08;
  localparam logic [7:0] OFF_INT_PND = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int         FLAG0_DIR_BIT = 1;
  localparam int         FLAG0_OUT_BIT = 2;
  localparam int         FLAG0_IN_BIT  = 3;
  localparam int         FLAG1_DIR_BIT = 5;
  localparam int         FLAG1_OUT_BIT = 6;
  localparam int         FLAG1_IN_BIT  = 7;
  localparam int         EDGE_SEL_BIT  = 0;
  localparam logic [2:0] WAIT_RESET    = 3'h7;
  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         HOLD_MAX_CYC  = 9;
  localparam int         RESET_MIN_H1  = 10;
  localparam logic [1:0] REARM_H1      = 2'h2;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } ahb_req_t;
  typedef struct packed {
    logic out;
    logic oe;
  } flag_pin_t;
  typedef enum logic [1:0] {BOOT_SYNC, BOOT_FETCH, BOOT_RUN} boot_state_t;
endpackage : pin_ctrl_pkg

// File: tb/board_model.sv
// Board side model: flag pin wire and interrupt pulse source
module board_model (
  input  wire logic       hclk,
  input  wire logic [1:0] user_flag_out,
  input  wire logic [1:0] user_flag_oe,
  input  wire logic [1:0] board_level,
  input  wire logic [3:0] pulse_go,
  input  wire logic [3:0] pulse_len,
  output logic      [1:0] user_flag_in,
  output logic      [3:0] external_interrupt_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic [3:0] sel = 4'h0;
  // Driving end wins, else the board level
  assign user_flag_in[0] = user_flag_oe[0] ? user_flag_out[0] : board_level[0];
  assign user_flag_in[1] = user_flag_oe[1] ? user_flag_out[1] : board_level[1];
  // pulse held low for a whole count, high between pulses
  assign external_interrupt_pin_n = ~(sel & {4{cnt != 4'h0}});
  always @(posedge hclk) begin
    if (pulse_go != 4'h0) begin
      cnt <= pulse_len;
      sel <= pulse_go;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : board_model

// File: tb/test_flag_reset_interrupt_pins.sv
// Bench: pin controller driven over AHB-Lite with a board model
module test_flag_reset_interrupt_pins;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, got, seed;
  logic [1:0]  htrans, user_flag_in, user_flag_out, user_flag_oe;
  logic [1:0]  board_level, int_take_id;
  logic [2:0]  hsize;
  logic [3:0]  pulse_go, pulse_len, external_interrupt_pin_n, int_pending;
  logic        clock_div2_mode, microcomputer_mode, serial_timer_oe;
  logic        addr_oe, page_strobes_oe, data_oe, strobe_n, rw;
  logic        interrupt_acknowledge_out_n, vector_fetch, hold_req;
  logic        hold_acknowledge, fetch_boundary, int_take;
  logic [31:0] exp_q[$];
  int          mismatches = 0;
  int          n_compared = 0;
  event        rd_ev;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  pin_ctrl pin_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .clock_div2_mode(clock_div2_mode),
    .microcomputer_mode(microcomputer_mode), .user_flag_in(user_flag_in),
    .user_flag_out(user_flag_out), .user_flag_oe(user_flag_oe),
    .serial_timer_oe(serial_timer_oe), .addr_oe(addr_oe),
    .page_strobes_oe(page_strobes_oe), .data_oe(data_oe),
    .strobe_n(strobe_n), .rw(rw),
    .interrupt_acknowledge_out_n(interrupt_acknowledge_out_n),
    .vector_fetch(vector_fetch), .hold_req(hold_req),
    .hold_acknowledge(hold_acknowledge),
    .external_interrupt_pin_n(external_interrupt_pin_n),
    .fetch_boundary(fetch_boundary), .int_take(int_take),
    .int_take_id(int_take_id), .int_pending(int_pending));
  board_model board_model_inst (.hclk(hclk), .user_flag_out(user_flag_out),
    .user_flag_oe(user_flag_oe), .board_level(board_level),
    .pulse_go(pulse_go), .pulse_len(pulse_len), .user_flag_in(user_flag_in),
    .external_interrupt_pin_n(external_interrupt_pin_n));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Reads are judged by a separate watcher off the queue
  always @(rd_ev) begin
    chk(got, exp_q.pop_front());
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // ------------------------------------------------------------
  // Bus and pin drivers
  // ------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_of_test();
    end
  endtask : wait_ready
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    wait_ready();
    if (!w) begin
      exp_q.push_back(d & m);
      got = hrdata & m;
      ->rd_ev;
    end
  endtask : ahb
  task automatic pulse(input logic [3:0] m, input logic [3:0] len);
    pulse_len <= len;
    pulse_go  <= m;
    @(posedge hclk);
    pulse_go <= 4'h0;
  endtask : pulse
  task automatic do_reset(input logic m);
    int n;
    int t0;
    int t1;
    int cnt;
    @(posedge hclk);
    #3 hresetn = 1'b0;
    #1;
    // pins float at once, without a clock
    chk(32'({user_flag_oe, serial_timer_oe}), 32'h0);
    chk(32'({addr_oe, page_strobes_oe, data_oe}), 32'h0);
    chk(32'({strobe_n, rw, interrupt_acknowledge_out_n}), 32'h7);
    microcomputer_mode <= m;
    hold_req <= 1'b1;
    // board holds reset for twelve clock cycles
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    while (hold_acknowledge !== 1'b1 && n < 12) begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n <= 9), 32'h1);
    hold_req <= 1'b0;
    cnt = 0;
    t0 = 0;
    t1 = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge hclk);
      if (vector_fetch === 1'b1) begin
        cnt++;
        if (cnt == 1) t0 = i;
        else t1 = i;
      end
    end
    chk(32'(cnt), 32'h2);
    chk(32'(t1 - t0), m ? 32'h1 : 32'h8);
  endtask : do_reset
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int n;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; clock_div2_mode = 1'b0;
    microcomputer_mode = 1'b0; hold_req = 1'b0; fetch_boundary = 1'b0;
    int_take = 1'b0; int_take_id = 2'h0; board_level = 2'h0;
    pulse_go = 4'h0; pulse_len = 4'h0; seed = 32'hb93f;
    do_reset(1'b1);
    do_reset(1'b0);
    ahb(1'b0, pin_ctrl_pkg::OFF_BUS_CTL, 32'h7, 32'h7);
    ahb(1'b0, 8'h40, 32'h0, 32'hffffffff);
    seed = lfsr_next(seed);
    ahb(1'b1, pin_ctrl_pkg::OFF_BUS_CTL, seed, 32'h0);
    ahb(1'b0, pin_ctrl_pkg::OFF_BUS_CTL, seed, 32'h7);
    // flags out, then back to inputs
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      clock_div2_mode <= i[0];
      v = {1'b0, seed[1], 2'h2, 1'b0, seed[0], 2'h2};
      ahb(1'b1, pin_ctrl_pkg::OFF_IO_FLAG, {24'h0, v}, 32'h0);
      repeat (i[0] ? 5 : 3) @(posedge hclk);
      #1;
      chk(32'(user_flag_oe), 32'h3);
      chk(32'(user_flag_out), 32'(seed[1:0]));
      board_level <= seed[3:2];
      ahb(1'b1, pin_ctrl_pkg::OFF_IO_FLAG, 32'h0, 32'h0);
      repeat (i[0] ? 5 : 3) @(posedge hclk);
      #1;
      chk(32'(user_flag_oe), 32'h0);
      repeat (4) @(posedge hclk);
      ahb(1'b0, pin_ctrl_pkg::OFF_IO_FLAG,
          {24'h0, seed[3], 3'h0, seed[2], 3'h0}, 32'h88);
    end
    clock_div2_mode <= 1'b0;
    // one short level pulse on each line
    ahb(1'b1, pin_ctrl_pkg::OFF_INT_CTL, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 4'h3);
      repeat (6) @(posedge hclk);
      chk(32'(int_pending), 32'h1 << i);
      ahb(1'b1, pin_ctrl_pkg::OFF_INT_PND, 32'h1 << i, 32'h0);
      ahb(1'b0, pin_ctrl_pkg::OFF_INT_PND, 32'h0, 32'hf);
    end
    // held low, the flag comes back soon after a clear
    // Low long enough to outlast the hold-off in either phase alignment
    pulse(4'h1, 4'hf);
    repeat (4) @(posedge hclk);
    ahb(1'b1, pin_ctrl_pkg::OFF_INT_PND, 32'h1, 32'h0);
    #1;
    chk(32'(int_pending), 32'h0);
    n = 0;
    while (int_pending[0] !== 1'b1 && n < 8) begin
      @(posedge hclk);
      n++;
    end
    chk(32'(int_pending), 32'h1);
    repeat (12) @(posedge hclk);
    ahb(1'b1, pin_ctrl_pkg::OFF_INT_PND, 32'hf, 32'h0);
    // edge mode sets once however long the line stays low
    ahb(1'b1, pin_ctrl_pkg::OFF_INT_CTL, 32'h1, 32'h0);
    pulse(4'h2, 4'hc);
    repeat (4) @(posedge hclk);
    chk(32'(int_pending), 32'h2);
    ahb(1'b1, pin_ctrl_pkg::OFF_INT_PND, 32'h2, 32'h0);
    repeat (6) @(posedge hclk);
    chk(32'(int_pending), 32'h0);
    repeat (8) @(posedge hclk);
    // a take only counts at a fetch boundary
    pulse(4'h4, 4'h3);
    repeat (6) @(posedge hclk);
    int_take <= 1'b1;
    int_take_id <= 2'h2;
    repeat (3) @(posedge hclk);
    chk(32'(int_pending), 32'h4);
    fetch_boundary <= 1'b1;
    @(posedge hclk);
    fetch_boundary <= 1'b0;
    int_take <= 1'b0;
    #1;
    chk(32'(int_pending), 32'h0);
    chk(32'(interrupt_acknowledge_out_n), 32'h0);
    end_of_test();
  end
endmodule : test_flag_reset_interrupt_pins
